// ### hdl/dtc_timer_pair.v
// Control logic of an 8-bit and a 16-bit counter/timer pair
// Function
// - Mode bit selects transmit or demodulation
// - Transmit: combined output steering and logic
// - Demodulation: input pin and edge select
// - Comparator pin captures also raise request two
// - Bit 1: start level or rise flag
// - Bit 0: start level or fall flag
// - 8-bit timer modulo reload or single pass
// - 8-bit timeout flag, write one clears
// - 8-bit timeout interrupt enable
// - 8-bit capture interrupt enable
// - 8-bit pin routes timer or port
// - First count tick may be short
// - 16-bit every edge or first edge
// - 16-bit timeout flag, write one clears
// - 16-bit capture interrupt enable
// - 16-bit timeout interrupt enable
// - 16-bit pin routes timer or port
// - Enable bits start, stop, read run state
// - Sync mode bit, default off
// - Demodulation glitch filter select
// - Sync aligns first carrier pulse
// - Transmit codes force 16-bit output
// - 16-bit load, count down, toggle at zero
`timescale 1ns/100ps
`include "dtc_defs.vh"
module dtc_timer_pair (
   input  wire       CLOCK,
   input  wire       RESETN,
   input  wire [3:0] REG_ADDR,
   input  wire       REG_WR,
   input  wire [7:0] REG_WDATA,
   output reg  [7:0] REG_RDATA,
   input  wire       EIGHT_PORT_LATCH,
   input  wire       SIXTEEN_PORT_LATCH,
   input  wire       COMB_PORT_LATCH,
   input  wire       COMPARATOR_CAPABLE_INPUT_PIN,
   input  wire       SECOND_PORT_INPUT_PIN,
   output reg        EIGHT_BIT_TIMER_PIN,
   output reg        SIXTEEN_BIT_TIMER_PIN,
   output reg        COMBINED_OUTPUT_PIN,
   output reg        EIGHT_IRQ,
   output reg        SIXTEEN_IRQ,
   output reg        INTERRUPT_REQUEST_TWO
);
   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   reg  [6:0]  ctl8_reg;
   reg  [6:0]  ctl16_reg;
   reg  [7:0]  com_reg;
   reg         en8_reg;
   reg         en16_reg;
   reg         sync_reg;
   reg         to8_reg;
   reg         to16_reg;
   reg         rise_flag_reg;
   reg         fall_flag_reg;
   reg  [7:0]  rld8h_reg;
   reg  [7:0]  rld8l_reg;
   reg  [7:0]  rld16h_reg;
   reg  [7:0]  rld16l_reg;
   reg  [7:0]  cap8l_reg;
   reg  [7:0]  cap8h_reg;
   reg  [15:0] cap16_reg;
   reg  [7:0]  cnt8_reg;
   reg  [15:0] cnt16_reg;
   reg         out8_reg;
   reg         out16_reg;
   reg         wait8_reg;
   reg         first_reg;
   reg  [2:0]  presc_reg;
   reg  [1:0]  pa_sync_reg;
   reg  [1:0]  pb_sync_reg;
   reg  [7:0]  rd_next;
   // ------------------------------------------------------------
   // Decodes
   // ------------------------------------------------------------
   wire        wr_c8    = REG_WR && (REG_ADDR == `DTC_OFS_CTL8);
   wire        wr_com   = REG_WR && (REG_ADDR == `DTC_OFS_COMMON);
   wire        wr_c16   = REG_WR && (REG_ADDR == `DTC_OFS_CTL16);
   wire        wr_es    = REG_WR && (REG_ADDR == `DTC_OFS_ENSYNC);
   wire        demod    = com_reg[`DTC_B_MODE];
   wire        w8_on    = (wr_c8 && REG_WDATA[`DTC_B_ENABLE]) ||
                          (wr_es && REG_WDATA[6]);
   wire        w8_off   = (wr_c8 && !REG_WDATA[`DTC_B_ENABLE]) ||
                          (wr_es && !REG_WDATA[6]);
   wire        w16_on   = (wr_c16 && REG_WDATA[`DTC_B_ENABLE]) ||
                          (wr_es && REG_WDATA[7]);
   wire        w16_off  = (wr_c16 && !REG_WDATA[`DTC_B_ENABLE]) ||
                          (wr_es && !REG_WDATA[7]);
   // Free prescaler, first tick may come early
   function tick_of;
      input [1:0] sel;
      input [2:0] p;
      begin
         case (sel)
            2'b00:   tick_of = 1'b1;
            2'b01:   tick_of = p[0];
            2'b10:   tick_of = &p[1:0];
            default: tick_of = &p;
         endcase
      end
   endfunction
   wire        tick8    = tick_of(ctl8_reg[4:3], presc_reg);
   wire        tick16   = tick_of(ctl16_reg[4:3], presc_reg);
   // ------------------------------------------------------------
   // Input selection, filter and edges
   // ------------------------------------------------------------
   wire        f_rise;
   wire        f_fall;
   wire        sel_in   = com_reg[`DTC_B_ROUTE_SEL] ? pb_sync_reg[1]
                                                     : pa_sync_reg[1];
   dtc_filter u_filt (
      .CLOCK     (CLOCK),
      .RESETN    (RESETN),
      .din       (sel_in),
      .filt_sel  (demod ? com_reg[3:2] : `DTC_FILT_NONE),
      .level_reg (),
      .rise_reg  (f_rise),
      .fall_reg  (f_fall)
   );
   // Edge select, code 11 takes nothing
   wire        edge_ev  = demod &&
      ((f_fall && (com_reg[5:4] == 2'b00 || com_reg[5:4] == 2'b10)) ||
       (f_rise && (com_reg[5:4] == 2'b01 || com_reg[5:4] == 2'b10)));
   // Every edge or first edge only
   wire        cap16_ev = edge_ev && en16_reg &&
                          (!ctl16_reg[`DTC_B_SINGLE] || !first_reg);
   wire        cap8_ev  = edge_ev && en8_reg;
   wire        z8       = en8_reg && !wait8_reg && tick8 &&
                          (cnt8_reg == 8'h00) && !cap8_ev;
   wire        z16      = en16_reg && tick16 &&
                          (cnt16_reg == 16'h0000) && !cap16_ev;
   wire        o16_eff  = (!demod && com_reg[3]) ? com_reg[2] : out16_reg;
   reg         comb;
   always @* begin
      case (com_reg[5:4])
         2'b00:   comb = out8_reg & o16_eff;
         2'b01:   comb = out8_reg | o16_eff;
         2'b10:   comb = ~(out8_reg | o16_eff);
         default: comb = ~(out8_reg & o16_eff);
      endcase
   end
   // ------------------------------------------------------------
   // Register writes and status flags
   // ------------------------------------------------------------
   always @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         ctl8_reg      <= 7'h00;
         ctl16_reg     <= 7'h00;
         com_reg       <= `DTC_RST_BYTE;
         sync_reg      <= 1'b0;
         to8_reg       <= 1'b0;
         to16_reg      <= 1'b0;
         rise_flag_reg <= 1'b0;
         fall_flag_reg <= 1'b0;
         rld8h_reg     <= `DTC_RST_BYTE;
         rld8l_reg     <= `DTC_RST_BYTE;
         rld16h_reg    <= `DTC_RST_BYTE;
         rld16l_reg    <= `DTC_RST_BYTE;
         presc_reg     <= 3'h0;
         pa_sync_reg   <= 2'b00;
         pb_sync_reg   <= 2'b00;
      end else begin
         presc_reg   <= presc_reg + 3'h1;
         pa_sync_reg <= {pa_sync_reg[0], COMPARATOR_CAPABLE_INPUT_PIN};
         pb_sync_reg <= {pb_sync_reg[0], SECOND_PORT_INPUT_PIN};
         if (wr_c8)
            ctl8_reg <= {REG_WDATA[6], 1'b0, REG_WDATA[4:0]};
         if (wr_c16)
            ctl16_reg <= {REG_WDATA[6], 1'b0, REG_WDATA[4:0]};
         if (wr_es)
            sync_reg <= REG_WDATA[`DTC_B_SYNC];
         if (wr_com)
            com_reg <= REG_WDATA;
         if (REG_WR && REG_ADDR == `DTC_OFS_RLD8_HI)
            rld8h_reg <= REG_WDATA;
         if (REG_WR && REG_ADDR == `DTC_OFS_RLD8_LO)
            rld8l_reg <= REG_WDATA;
         if (REG_WR && REG_ADDR == `DTC_OFS_RLD16_HI)
            rld16h_reg <= REG_WDATA;
         if (REG_WR && REG_ADDR == `DTC_OFS_RLD16_LO)
            rld16l_reg <= REG_WDATA;
         if (z8)
            to8_reg <= 1'b1;
         else if (wr_c8 && REG_WDATA[`DTC_B_TIMEOUT])
            to8_reg <= 1'b0;
         if (z16)
            to16_reg <= 1'b1;
         else if (wr_c16 && REG_WDATA[`DTC_B_TIMEOUT])
            to16_reg <= 1'b0;
         if (demod && f_rise)
            rise_flag_reg <= 1'b1;
         else if (wr_com && demod && REG_WDATA[1])
            rise_flag_reg <= 1'b0;
         if (demod && f_fall)
            fall_flag_reg <= 1'b1;
         else if (wr_com && demod && REG_WDATA[0])
            fall_flag_reg <= 1'b0;
         if (wr_com && demod)
            com_reg <= {REG_WDATA[7:2], com_reg[1:0]};
      end
   end
   // ------------------------------------------------------------
   // 8-bit timer
   // ------------------------------------------------------------
   always @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         en8_reg   <= 1'b0;
         cnt8_reg  <= 8'h00;
         out8_reg  <= 1'b0;
         wait8_reg <= 1'b0;
         cap8l_reg <= 8'h00;
         cap8h_reg <= 8'h00;
      end else begin
         if (w8_on && !en8_reg) begin
            en8_reg   <= 1'b1;
            out8_reg  <= com_reg[1];
            cnt8_reg  <= com_reg[1] ? rld8h_reg : rld8l_reg;
            wait8_reg <= sync_reg;
         end else if (w8_off) begin
            en8_reg <= 1'b0;
         // Hold until effective 16-bit output goes high
         end else if (wait8_reg) begin
            if (o16_eff) begin
               wait8_reg <= 1'b0;
               cnt8_reg  <= out8_reg ? rld8h_reg : rld8l_reg;
            end
         end else if (cap8_ev) begin
            if (f_rise)
               cap8h_reg <= cnt8_reg;
            else
               cap8l_reg <= cnt8_reg;
            cnt8_reg <= rld8l_reg;
         end else if (z8) begin
            if (ctl8_reg[`DTC_B_SINGLE])
               en8_reg <= 1'b0;
            out8_reg <= ~out8_reg;
            cnt8_reg <= out8_reg ? rld8l_reg : rld8h_reg;
         end else if (en8_reg && tick8) begin
            cnt8_reg <= cnt8_reg - 8'h01;
         end
      end
   end
   // ------------------------------------------------------------
   // 16-bit timer
   // ------------------------------------------------------------
   always @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         en16_reg  <= 1'b0;
         cnt16_reg <= 16'h0000;
         out16_reg <= 1'b0;
         first_reg <= 1'b0;
         cap16_reg <= 16'h0000;
      end else begin
         // Load high and low reload bytes
         if (w16_on && !en16_reg) begin
            en16_reg  <= 1'b1;
            out16_reg <= com_reg[0];
            cnt16_reg <= {rld16h_reg, rld16l_reg};
            first_reg <= 1'b0;
         end else if (w16_off) begin
            en16_reg <= 1'b0;
         end else if (cap16_ev) begin
            cap16_reg <= cnt16_reg;
            cnt16_reg <= {rld16h_reg, rld16l_reg};
            first_reg <= 1'b1;
         end else if (z16) begin
            out16_reg <= ~out16_reg;
            if (ctl16_reg[`DTC_B_SINGLE] && !demod)
               en16_reg <= 1'b0;
            cnt16_reg <= {rld16h_reg, rld16l_reg};
         end else if (en16_reg && tick16) begin
            cnt16_reg <= cnt16_reg - 16'h0001;
         end
      end
   end
   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   always @* begin
      case (REG_ADDR)
         `DTC_OFS_CTL8:     rd_next = {en8_reg, ctl8_reg[6], to8_reg,
                                       ctl8_reg[4:0]};
         `DTC_OFS_COMMON:   rd_next = demod ?
            {com_reg[7:2], rise_flag_reg, fall_flag_reg} : com_reg;
         `DTC_OFS_CTL16:    rd_next = {en16_reg, ctl16_reg[6], to16_reg,
                                       ctl16_reg[4:0]};
         `DTC_OFS_ENSYNC:   rd_next = {en16_reg, en8_reg, sync_reg,
                                       `DTC_ENSYNC_RSVD};
         `DTC_OFS_RLD8_HI:  rd_next = rld8h_reg;
         `DTC_OFS_RLD8_LO:  rd_next = rld8l_reg;
         `DTC_OFS_RLD16_HI: rd_next = rld16h_reg;
         `DTC_OFS_RLD16_LO: rd_next = rld16l_reg;
         `DTC_OFS_CAP16_LO: rd_next = cap16_reg[7:0];
         `DTC_OFS_CAP16_HI: rd_next = cap16_reg[15:8];
         `DTC_OFS_CAP8_LO:  rd_next = cap8l_reg;
         `DTC_OFS_CAP8_HI:  rd_next = cap8h_reg;
         default:           rd_next = 8'h00;
      endcase
   end
   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   always @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         REG_RDATA             <= 8'h00;
         EIGHT_BIT_TIMER_PIN   <= 1'b0;
         SIXTEEN_BIT_TIMER_PIN <= 1'b0;
         COMBINED_OUTPUT_PIN   <= 1'b0;
         EIGHT_IRQ             <= 1'b0;
         SIXTEEN_IRQ           <= 1'b0;
         INTERRUPT_REQUEST_TWO <= 1'b0;
      end else begin
         REG_RDATA <= rd_next;
         EIGHT_BIT_TIMER_PIN <= ctl8_reg[`DTC_B_ROUTE] ? out8_reg
                                                       : EIGHT_PORT_LATCH;
         SIXTEEN_BIT_TIMER_PIN <= ctl16_reg[`DTC_B_ROUTE] ? o16_eff
                                                          : SIXTEEN_PORT_LATCH;
         COMBINED_OUTPUT_PIN <= (!demod && com_reg[`DTC_B_ROUTE_SEL]) ?
                                comb : COMB_PORT_LATCH;
         EIGHT_IRQ <= (z8 && ctl8_reg[`DTC_B_TO_IE]) ||
                      (cap8_ev && !wait8_reg && ctl8_reg[`DTC_B_CAP_IE]);
         SIXTEEN_IRQ <= (z16 && ctl16_reg[`DTC_B_TO_IE]) ||
                        (cap16_ev && ctl16_reg[`DTC_B_CAP_IE]);
         INTERRUPT_REQUEST_TWO <= (cap8_ev || cap16_ev) &&
                                  !com_reg[`DTC_B_ROUTE_SEL];
      end
   end
endmodule // dtc_timer_pair

// ### hdl/dtc_defs.vh
// Constants for the dual timer carrier and demodulation block
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define DTC_OFS_CTL8      4'h0
`define DTC_OFS_COMMON    4'h1
`define DTC_OFS_CTL16     4'h2
`define DTC_OFS_ENSYNC    4'h3
`define DTC_OFS_RLD8_HI   4'h4
`define DTC_OFS_RLD8_LO   4'h5
`define DTC_OFS_RLD16_HI  4'h6
`define DTC_OFS_RLD16_LO  4'h7
`define DTC_OFS_CAP16_LO  4'h8
`define DTC_OFS_CAP16_HI  4'h9
`define DTC_OFS_CAP8_LO   4'hA
`define DTC_OFS_CAP8_HI   4'hB
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define DTC_B_ENABLE      7
`define DTC_B_SINGLE      6
`define DTC_B_TIMEOUT     5
`define DTC_B_CAP_IE      2
`define DTC_B_TO_IE       1
`define DTC_B_ROUTE       0
`define DTC_B_MODE        7
`define DTC_B_ROUTE_SEL   6
`define DTC_B_SYNC        5
// ------------------------------------------------------------
// Reset values and codes
// ------------------------------------------------------------
`define DTC_RST_BYTE      8'h00
`define DTC_ENSYNC_RSVD   5'h1F
`define DTC_FILT_NONE     2'b00
`define DTC_FILT_4        2'b01
`define DTC_FILT_8        2'b10
`define DTC_FILT_CNT4     4'h4
`define DTC_FILT_CNT8     4'h8
`define DTC_FILT_CNT0     4'h1
`endif

// ### hdl/dtc_filter.v
// Glitch filter and edge detector for the demodulation input
`timescale 1ns/100ps
`include "dtc_defs.vh"
module dtc_filter (
   input  wire       CLOCK,
   input  wire       RESETN,
   input  wire       din,
   input  wire [1:0] filt_sel,
   output reg        level_reg,
   output reg        rise_reg,
   output reg        fall_reg
);
   reg  [3:0] cnt_reg;
   reg  [3:0] need;
   // ------------------------------------------------------------
   // Stable time select
   // ------------------------------------------------------------
   always @* begin
      case (filt_sel)
         `DTC_FILT_4: need = `DTC_FILT_CNT4;
         `DTC_FILT_8: need = `DTC_FILT_CNT8;
         default:     need = `DTC_FILT_CNT0;
      endcase
   end
   // ------------------------------------------------------------
   // Accept a new level once stable long enough
   // ------------------------------------------------------------
   always @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         cnt_reg   <= 4'h0;
         level_reg <= 1'b0;
         rise_reg  <= 1'b0;
         fall_reg  <= 1'b0;
      end else begin
         rise_reg <= 1'b0;
         fall_reg <= 1'b0;
         if (din == level_reg) begin
            cnt_reg <= 4'h0;
         end else if (cnt_reg + 4'h1 >= need) begin
            cnt_reg   <= 4'h0;
            level_reg <= din;
            rise_reg  <= din;
            fall_reg  <= ~din;
         end else begin
            cnt_reg <= cnt_reg + 4'h1;
         end
      end
   end
endmodule // dtc_filter

// ### verification/dtc_monitor.sv
// Assertion checker of the timer pair ports
`timescale 1ns/100ps
module dtc_monitor (
   input wire       CLOCK,
   input wire       RESETN,
   input wire [3:0] REG_ADDR,
   input wire       REG_WR,
   input wire [7:0] REG_WDATA,
   input wire [7:0] REG_RDATA,
   input wire       EIGHT_PORT_LATCH,
   input wire       SIXTEEN_PORT_LATCH,
   input wire       COMB_PORT_LATCH,
   input wire       EIGHT_BIT_TIMER_PIN,
   input wire       SIXTEEN_BIT_TIMER_PIN,
   input wire       COMBINED_OUTPUT_PIN,
   input wire       EIGHT_IRQ,
   input wire       SIXTEEN_IRQ,
   input wire       INTERRUPT_REQUEST_TWO
);
   // ----------------------------------------------------
   // Shadow of written control fields
   // ----------------------------------------------------
   reg [2:0] c8_reg;
   reg [2:0] c16_reg;
   reg [5:0] cm_reg;
   always @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         c8_reg  <= 3'h0;
         c16_reg <= 3'h0;
         cm_reg  <= 6'h00;
      end else if (REG_WR) begin
         if (REG_ADDR == 4'h0) c8_reg <= REG_WDATA[2:0];
         if (REG_ADDR == 4'h2) c16_reg <= REG_WDATA[2:0];
         if (REG_ADDR == 4'h1) cm_reg <= REG_WDATA[7:2];
      end
   end
   // ----------------------------------------------------
   // Assertions
   // ----------------------------------------------------
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RESETN);
   a_ensync_fixed_bits: assert property (
      $past(RESETN) && $past(REG_ADDR) == 4'h3 |-> REG_RDATA[4:0] == 5'h1F)
      else $error("enable register low bits wrong");
   a_unmapped_read: assert property (
      $past(RESETN) && $past(REG_ADDR) >= 4'hC |-> REG_RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_eight_pin_port: assert property (
      $past(RESETN) && !$past(c8_reg[0])
      |-> EIGHT_BIT_TIMER_PIN == $past(EIGHT_PORT_LATCH))
      else $error("eight bit pin not port latch");
   a_sixteen_pin_port: assert property (
      $past(RESETN) && !$past(c16_reg[0])
      |-> SIXTEEN_BIT_TIMER_PIN == $past(SIXTEEN_PORT_LATCH))
      else $error("sixteen bit pin not port latch");
   a_comb_pin_port: assert property (
      $past(RESETN) && $past(cm_reg[5:4]) == 2'b00
      |-> COMBINED_OUTPUT_PIN == $past(COMB_PORT_LATCH))
      else $error("combined pin not port latch");
   a_forced_sixteen: assert property (
      $past(RESETN) && $past(c16_reg[0]) && $past(cm_reg[5:4]) == 2'b01
      && $past(cm_reg[1]) |-> SIXTEEN_BIT_TIMER_PIN == $past(cm_reg[0]))
      else $error("forced sixteen bit output wrong");
   a_req_two_source: assert property (
      INTERRUPT_REQUEST_TWO |-> $past(cm_reg[5:4]) == 2'b10)
      else $error("request two without comparator input");
   a_eight_irq_pulse: assert property (
      EIGHT_IRQ |-> $past(c8_reg[2:1]) != 2'b00 ##1 !EIGHT_IRQ)
      else $error("eight bit request not enabled or too long");
   a_sixteen_irq_pulse: assert property (
      SIXTEEN_IRQ |-> $past(c16_reg[2:1]) != 2'b00 ##1 !SIXTEEN_IRQ)
      else $error("sixteen bit request not enabled or too long");
   a_req_two_pulse: assert property (
      $rose(INTERRUPT_REQUEST_TWO) |=> !INTERRUPT_REQUEST_TWO)
      else $error("request two longer than one cycle");
endmodule // dtc_monitor

// ### verification/dtc_pulse_src.sv
// Model of the external modulated signal source
`timescale 1ns/100ps
module dtc_pulse_src (
   input  wire clock,
   output reg  pin_a,
   output reg  pin_b
);
   // ----------------------------------------------------
   // Idle low, pulses of a set width on one pin
   // ----------------------------------------------------
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b0;
   end
   task pulse(input bit sel, input int width);
      @(negedge clock);
      if (sel) pin_b = 1'b1;
      else pin_a = 1'b1;
      repeat (width) @(negedge clock);
      pin_a = 1'b0;
      pin_b = 1'b0;
      repeat (16) @(negedge clock);
   endtask
endmodule // dtc_pulse_src

// ### verification/tb.sv
// Self-checking testbench of the dual timer pair
`timescale 1ns/100ps
module tb;
   reg        clock;
   reg        resetn;
   reg  [3:0] reg_addr;
   reg        reg_wr;
   reg  [7:0] reg_wdata;
   wire [7:0] reg_rdata;
   reg        lat8, lat16, latc;
   wire       pin_a, pin_b, pin8, pin16, pinc;
   wire       irq8, irq16, interrupt_request_two;
   reg  [7:0] rdv;
   integer    fails, check_count, n8, n16, n2;
   dtc_timer_pair u_dtc_timer_pair (
      .CLOCK(clock), .RESETN(resetn), .REG_ADDR(reg_addr),
      .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
      .EIGHT_PORT_LATCH(lat8), .SIXTEEN_PORT_LATCH(lat16),
      .COMB_PORT_LATCH(latc), .COMPARATOR_CAPABLE_INPUT_PIN(pin_a),
      .SECOND_PORT_INPUT_PIN(pin_b), .EIGHT_BIT_TIMER_PIN(pin8),
      .SIXTEEN_BIT_TIMER_PIN(pin16), .COMBINED_OUTPUT_PIN(pinc),
      .EIGHT_IRQ(irq8), .SIXTEEN_IRQ(irq16),
      .INTERRUPT_REQUEST_TWO(interrupt_request_two));
   dtc_pulse_src u_dtc_pulse_src (
      .clock(clock), .pin_a(pin_a), .pin_b(pin_b));
   // ----------------------------------------------------
   // Clock, event counters and shared tasks
   // ----------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(negedge clock) begin
      if (irq8 === 1'b1) n8 = n8 + 1;
      if (irq16 === 1'b1) n16 = n16 + 1;
      if (interrupt_request_two === 1'b1) n2 = n2 + 1;
   end
   task chk(input [7:0] seen, input [7:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input [3:0] a, input [7:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clock);
      reg_wr = 1'b0;
   endtask
   task rdchk(input [3:0] a, input [7:0] e);
      @(negedge clock);
      reg_addr = a;
      @(negedge clock);
      rdv = reg_rdata;
      chk(rdv, e);
   endtask
   task stop_test;
      $display("Checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ----------------------------------------------------
   // Scenarios
   // ----------------------------------------------------
   task t_reset;
      rdchk(4'h0, 8'h00);
      rdchk(4'h1, 8'h00);
      rdchk(4'h3, 8'h1F);
      rdchk(4'hC, 8'h00);
      wr(4'h3, 8'h20);
      rdchk(4'h3, 8'h3F);
      wr(4'h3, 8'h00);
   endtask
   task t_pins;
      integer k;
      for (k = 0; k < 2; k = k + 1) begin
         lat8 = k[0];
         lat16 = ~k[0];
         latc = k[0];
         repeat (2) @(negedge clock);
         chk({7'h0, pin8}, k[7:0]);
         chk({7'h0, pin16}, {7'h0, ~k[0]});
         chk({7'h0, pinc}, k[7:0]);
      end
   endtask
   task t_timer16;
      integer i;
      wr(4'h6, 8'h00);
      wr(4'h7, 8'h02);
      wr(4'h2, 8'h22);
      wr(4'h3, 8'h80);
      i = 0;
      while (irq16 !== 1'b1 && i < 20) begin
         @(negedge clock);
         i = i + 1;
      end
      chk(i[7:0], 8'h03);
      if (i == 20) stop_test;
      rdchk(4'h3, 8'h9F);
      wr(4'h3, 8'h00);
      wr(4'h2, 8'h02);
      rdchk(4'h2, 8'h22);
      wr(4'h2, 8'h22);
      rdchk(4'h2, 8'h02);
   endtask
   task t_timer8;
      integer k;
      reg [7:0] c;
      wr(4'h4, 8'h03);
      wr(4'h5, 8'h03);
      for (k = 0; k < 3; k = k + 1) begin
         c = (k == 0) ? 8'h42 : (k == 1) ? 8'h02 : 8'h00;
         wr(4'h0, c | 8'h20);
         n8 = 0;
         wr(4'h3, 8'h40);
         rdchk(4'h3, 8'h5F);
         repeat (60) @(negedge clock);
         wr(4'h3, 8'h00);
         wr(4'h0, c);
         rdchk(4'h0, c | 8'h20);
         wr(4'h0, c | 8'h20);
         rdchk(4'h0, c);
         if (k == 0) chk(n8[7:0], 8'h01);
         if (k == 1) chk({7'h0, n8 >= 8}, 8'h01);
         if (k == 2) chk(n8[7:0], 8'h00);
      end
   endtask
   task t_combine;
      integer k;
      reg e;
      wr(4'h0, 8'h01);
      wr(4'h2, 8'h01);
      for (k = 0; k < 16; k = k + 1) begin
         wr(4'h1, {2'b01, k[1:0], 1'b1, k[2], k[3], 1'b0});
         repeat (3) @(negedge clock);
         chk({7'h0, pin16}, {7'h0, k[2]});
         case (k[1:0])
            2'b00: e = pin8 & k[2];
            2'b01: e = pin8 | k[2];
            2'b10: e = ~(pin8 | k[2]);
            default: e = ~(pin8 & k[2]);
         endcase
         chk({7'h0, pinc}, {7'h0, e});
      end
      wr(4'h1, 8'h00);
      wr(4'h0, 8'h00);
   endtask
   task t_demod;
      wr(4'h0, 8'h04);
      wr(4'h2, 8'h04);
      wr(4'h1, 8'hA0);
      wr(4'h3, 8'hC0);
      n8 = 0;
      n16 = 0;
      n2 = 0;
      u_dtc_pulse_src.pulse(1'b0, 6);
      chk(n2[7:0], 8'h02);
      chk(n8[7:0], 8'h02);
      chk(n16[7:0], 8'h02);
      rdchk(4'h1, 8'hA3);
      // Flags cleared one at a time
      wr(4'h1, 8'hA2);
      rdchk(4'h1, 8'hA1);
      wr(4'h1, 8'hA1);
      rdchk(4'h1, 8'hA0);
      wr(4'h1, 8'hD8);
      n2 = 0;
      n16 = 0;
      u_dtc_pulse_src.pulse(1'b1, 4);
      rdchk(4'h1, 8'hD8);
      u_dtc_pulse_src.pulse(1'b1, 12);
      rdchk(4'h1, 8'hDB);
      chk(n2[7:0], 8'h00);
      chk(n16[7:0], 8'h01);
      wr(4'h3, 8'h00);
      wr(4'h2, 8'h44);
      wr(4'h3, 8'hC0);
      n16 = 0;
      u_dtc_pulse_src.pulse(1'b1, 12);
      u_dtc_pulse_src.pulse(1'b1, 12);
      chk(n16[7:0], 8'h01);
      wr(4'h3, 8'h00);
   endtask
   task t_sync;
      wr(4'h0, 8'h22);
      wr(4'h1, 8'h08);
      wr(4'h3, 8'h20);
      wr(4'h3, 8'h60);
      n8 = 0;
      repeat (20) @(negedge clock);
      chk(n8[7:0], 8'h00);
      wr(4'h1, 8'h0C);
      repeat (20) @(negedge clock);
      chk({7'h0, n8 > 0}, 8'h01);
      wr(4'h3, 8'h00);
   endtask
   initial begin
      resetn = 1'b0;
      reg_addr = 4'h0;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      lat8 = 1'b0;
      lat16 = 1'b0;
      latc = 1'b0;
      fails = 0;
      check_count = 0;
      n8 = 0;
      n16 = 0;
      n2 = 0;
      repeat (6) @(negedge clock);
      resetn = 1'b1;
      t_reset;
      t_pins;
      t_timer16;
      t_timer8;
      t_combine;
      t_demod;
      t_sync;
      stop_test;
   end
endmodule // tb
bind dtc_timer_pair dtc_monitor u_dtc_monitor (
   .CLOCK(CLOCK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
   .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
   .EIGHT_PORT_LATCH(EIGHT_PORT_LATCH),
   .SIXTEEN_PORT_LATCH(SIXTEEN_PORT_LATCH),
   .COMB_PORT_LATCH(COMB_PORT_LATCH),
   .EIGHT_BIT_TIMER_PIN(EIGHT_BIT_TIMER_PIN),
   .SIXTEEN_BIT_TIMER_PIN(SIXTEEN_BIT_TIMER_PIN),
   .COMBINED_OUTPUT_PIN(COMBINED_OUTPUT_PIN), .EIGHT_IRQ(EIGHT_IRQ),
   .SIXTEEN_IRQ(SIXTEEN_IRQ),
   .INTERRUPT_REQUEST_TWO(INTERRUPT_REQUEST_TWO));
